// ===== rtl/dkc_dma_bus.sv
// Bus-side DMA engine: memory cycles, wait states, channel priority and slave FIFO access.
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module dkc_dma_bus
  import dkc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Disk-side word stream into the FIFO
  input  wire logic        disk_valid,
  output logic             disk_ready,
  input  wire logic [31:0] disk_data,
  // Memory bus
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  input  wire logic [31:0] mem_rdata,
  output logic             mem_ads,
  output logic             mem_rd,
  output logic             mem_wr,
  input  wire logic        external_wait_request,
  // Arbitration
  output logic             local_bus_request,
  input  wire logic        local_bus_grant,
  output logic             remote_bus_request,
  input  wire logic        remote_bus_grant,
  // Remote channel data out
  output logic [31:0]      rem_data,
  output logic             rem_valid,
  // Outside DMA controller access to the FIFO
  input  wire logic        xdma_rd,
  output logic [31:0]      xdma_rdata
);

  dkc_ctrl_s    ctrl_q;
  logic [3:0]   thr_q;
  logic [3:0]   blen_q;
  logic [31:0]  laddr_q;
  logic [31:0]  raddr_q;
  logic [15:0]  rcount_q;
  dkc_state_e   st_q;
  logic         rem_q;
  logic         last_q;
  logic         lrq_q;
  logic         rrq_q;
  logic [3:0]   burst_q;
  logic [31:0]  addr_q;
  logic [31:0]  wdata_q;
  logic [31:0]  rdat_q;
  logic         rval_q;
  logic [31:0]  xdat_q;
  logic [31:0]  prdata_q;
  logic         slverr_q;
  logic [31:0]  fifo_out;
  logic         fifo_vld;
  logic         fifo_pop;
  logic [LVL_W-1:0] lvl;
  logic         lpend;
  logic         rpend;
  logic         slow;
  logic         strobe;
  logic         last_c;
  logic         grant_c;
  logic         xpop;
  logic         wr_acc;
  logic         rd_setup;

  function automatic logic hit(input logic [7:0] a);
    hit = (a == ADDR_CTRL) | (a == ADDR_CFG) | (a == ADDR_LADDR) | (a == ADDR_RADDR)
        | (a == ADDR_RCOUNT) | (a == ADDR_STATUS);
  endfunction : hit

  // The FIFO is 8 words of 32 bits, the full 32-byte buffer.
  dkc_fifo #(.W(FIFO_WIDTH), .D(FIFO_WORDS), .L(LVL_W)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (disk_valid),
    .in_ready  (disk_ready),
    .in_data   (disk_data),
    .out_valid (fifo_vld),
    .out_ready (fifo_pop),
    .out_data  (fifo_out),
    .level     (lvl)
  );

  assign lpend   = ctrl_q.loc_en & (lvl >= thr_q) & (thr_q != '0);
  assign rpend   = ctrl_q.rem_en & (rcount_q != '0) & !ctrl_q.slave_mode;
  assign slow    = rem_q ? ctrl_q.remote_slow_strobe_bit : ctrl_q.local_slow_strobe_bit;
  assign grant_c = rem_q ? remote_bus_grant : local_bus_grant;
  assign xpop    = ctrl_q.slave_mode & lrq_q & local_bus_grant & xdma_rd & fifo_vld;
  assign fifo_pop = xpop | (st_q == S_T1 && !rem_q && fifo_vld);
  // A burst ends on the programmed count, or on the last FIFO word or remote count if sooner; until_empty drops the count.
  assign last_c  = (!ctrl_q.until_empty && burst_q == 4'h1)
                 | (rem_q ? (rcount_q == 16'h1) : (lvl == LVL_W'(1)));

  // Strobe covers the second state through the third, including every wait.
  assign strobe  = (st_q == S_T2) | (st_q == S_TWI) | (st_q == S_T3) | (st_q == S_TWE);
  assign mem_rd  = strobe & rem_q;
  assign mem_wr  = strobe & !rem_q;
  assign mem_ads = (st_q == S_T1);
  assign mem_addr  = addr_q;
  assign mem_wdata = wdata_q;
  assign local_bus_request  = lrq_q;
  assign remote_bus_request = rrq_q;
  assign rem_data   = rdat_q;
  assign rem_valid  = rval_q;
  assign xdma_rdata = xdat_q;

  // APB: read data is captured in the setup cycle, so pready can stay high.
  assign wr_acc   = psel & penable & pwrite & hit(paddr);
  assign rd_setup = psel & !penable;
  assign pready   = 1'b1;
  assign prdata   = prdata_q;
  assign pslverr  = slverr_q & psel & penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      slverr_q <= 1'b0;
    end else if (rd_setup) begin
      slverr_q <= !hit(paddr);
      case (paddr)
        ADDR_CTRL:   prdata_q <= {24'h0, ctrl_q};
        ADDR_CFG:    prdata_q <= {20'h0, blen_q, 4'h0, thr_q};
        ADDR_LADDR:  prdata_q <= laddr_q;
        ADDR_RADDR:  prdata_q <= raddr_q;
        ADDR_RCOUNT: prdata_q <= {16'h0, rcount_q};
        ADDR_STATUS: prdata_q <= {20'h0, 1'b0, st_q, rrq_q, lrq_q, 2'h0, lvl};
        default:     prdata_q <= '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
      thr_q  <= THR_RESET;
      blen_q <= BURST_RESET;
    end else if (wr_acc && paddr == ADDR_CTRL) begin
      ctrl_q <= pwdata[7:0];
    end else if (wr_acc && paddr == ADDR_CFG) begin
      thr_q  <= pwdata[CFG_THR_LSB +: 4];
      blen_q <= pwdata[CFG_BURST_LSB +: 4];
    end
  end

  // Channel addresses are full 32-bit counters, stepped after each cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      laddr_q  <= '0;
      raddr_q  <= '0;
      rcount_q <= '0;
    end else begin
      if (wr_acc && paddr == ADDR_LADDR) begin
        laddr_q <= pwdata;
      end else if (st_q == S_T4 && !rem_q) begin
        laddr_q <= laddr_q + ADDR_STEP;
      end
      if (wr_acc && paddr == ADDR_RADDR) begin
        raddr_q <= pwdata;
      end else if (st_q == S_T4 && rem_q) begin
        raddr_q <= raddr_q + ADDR_STEP;
      end
      if (wr_acc && paddr == ADDR_RCOUNT) begin
        rcount_q <= pwdata[15:0];
      end else if (st_q == S_T4 && rem_q && rcount_q != '0) begin
        rcount_q <= rcount_q - 16'h1;
      end
    end
  end

  // Cycle sequencer together with the two bus requests it owns.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= S_IDLE;
      rem_q   <= 1'b0;
      last_q  <= 1'b0;
      lrq_q   <= 1'b0;
      rrq_q   <= 1'b0;
      burst_q <= '0;
    end else begin
      case (st_q)
        S_IDLE: begin
          if (ctrl_q.slave_mode) begin
            // The request falls when the FIFO is drained; the grant must outlast it.
            if (!lrq_q && lpend) begin
              lrq_q <= 1'b1;
            end else if (lrq_q && (!fifo_vld || (xpop && lvl == LVL_W'(1)))) begin
              lrq_q <= 1'b0;
            end
          end else if (lpend) begin
            lrq_q   <= 1'b1;
            rem_q   <= 1'b0;
            burst_q <= blen_q;
            st_q    <= S_REQ;
          end else if (rpend) begin
            rrq_q   <= 1'b1;
            rem_q   <= 1'b1;
            burst_q <= blen_q;
            st_q    <= S_REQ;
          end
        end
        S_REQ: begin
          if (grant_c) begin
            st_q <= S_T1;
          end
        end
        S_T1: begin
          last_q <= last_c;
          if (last_c) begin
            lrq_q <= 1'b0;
            rrq_q <= 1'b0;
          end
          st_q <= S_T2;
        end
        S_T2: begin
          st_q <= slow ? S_TWI : S_T3;
        end
        S_TWI: begin
          st_q <= S_T3;
        end
        S_T3: begin
          if (ctrl_q.external_wait_enable && external_wait_request) begin
            st_q <= S_TWE;
          end else begin
            st_q <= S_T4;
          end
        end
        S_TWE: begin
          st_q <= external_wait_request ? S_TWE : S_T4;
        end
        S_T4: begin
          burst_q <= burst_q - 4'h1;
          if (grant_c && !last_q && !(rem_q && ctrl_q.tracking && lpend)) begin
            st_q <= S_T1;
          end else begin
            // The last cycle, a lost grant or, in tracking mode, a local need during a remote burst ends the burst and frees the bus.
            st_q  <= S_IDLE;
            lrq_q <= 1'b0;
            rrq_q <= 1'b0;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // Address is latched for the whole cycle; write data leave the FIFO in the first state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q  <= '0;
      wdata_q <= '0;
    end else if (st_q == S_REQ || (st_q == S_T4 && grant_c)) begin
      // The channel counter steps on this same edge, so T4 forms the next address itself.
      addr_q <= (rem_q ? raddr_q : laddr_q) + ((st_q == S_T4) ? ADDR_STEP : 32'h0000_0000);
    end else if (st_q == S_T1) begin
      addr_q <= rem_q ? raddr_q : laddr_q;
      if (!rem_q) begin
        wdata_q <= fifo_out;
      end
    end
  end

  // Remote read data is taken on the edge that leaves the last strobed state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdat_q <= '0;
      rval_q <= 1'b0;
      xdat_q <= '0;
    end else begin
      rval_q <= 1'b0;
      if (rem_q && ((st_q == S_T3 && !(ctrl_q.external_wait_enable && external_wait_request))
          || (st_q == S_TWE && !external_wait_request))) begin
        rdat_q <= mem_rdata;
        rval_q <= 1'b1;
      end
      if (xpop) begin
        xdat_q <= fifo_out;
      end
    end
  end

  property p_four_state;
    @(posedge pclk) disable iff (!presetn)
    (st_q == S_T1 && !slow && !ctrl_q.external_wait_enable)
      |=> (st_q == S_T2) ##1 (st_q == S_T3) ##1 (st_q == S_T4);
  endproperty
  a_four_state: assert property (p_four_state) else $error("cycle not four states");

  property p_fifo_size;
    @(posedge pclk) disable iff (!presetn) lvl <= LVL_W'(FIFO_WORDS);
  endproperty
  a_fifo_size: assert property (p_fifo_size) else $error("fifo above 32 bytes");

  property p_slow;
    @(posedge pclk) disable iff (!presetn)
    (st_q == S_T2 && slow) |=> (st_q == S_TWI) ##1 (st_q == S_T3);
  endproperty
  a_slow: assert property (p_slow) else $error("slow strobe wait missing");

  property p_wait_strobe;
    @(posedge pclk) disable iff (!presetn)
    (st_q == S_TWI || st_q == S_TWE) |-> (mem_rd ^ mem_wr);
  endproperty
  a_wait_strobe: assert property (p_wait_strobe) else $error("strobe off in wait");

  property p_ext_wait;
    @(posedge pclk) disable iff (!presetn)
    (st_q == S_T3 && ctrl_q.external_wait_enable && external_wait_request) |=> st_q == S_TWE;
  endproperty
  a_ext_wait: assert property (p_ext_wait) else $error("external wait not taken");

  property p_ext_end;
    @(posedge pclk) disable iff (!presetn)
    (st_q == S_TWE && !external_wait_request) |=> (st_q == S_T4 && !strobe);
  endproperty
  a_ext_end: assert property (p_ext_end) else $error("external wait not ended");

  property p_local_first;
    @(posedge pclk) disable iff (!presetn)
    (st_q == S_T4 && rem_q && ctrl_q.tracking && lpend) |=> (st_q == S_IDLE && !rrq_q);
  endproperty
  a_local_first: assert property (p_local_first) else $error("remote not interrupted");

  property p_grant_wait;
    @(posedge pclk) disable iff (!presetn)
    (st_q == S_REQ && !grant_c) |=> st_q == S_REQ;
  endproperty
  a_grant_wait: assert property (p_grant_wait) else $error("burst began without grant");

  property p_release;
    @(posedge pclk) disable iff (!presetn)
    (st_q == S_T4 && !grant_c) |=> (st_q == S_IDLE && !lrq_q && !rrq_q);
  endproperty
  a_release: assert property (p_release) else $error("bus kept without grant");

  property p_last_drop;
    @(posedge pclk) disable iff (!presetn)
    (st_q == S_T2 && last_q) |-> (!lrq_q && !rrq_q && strobe);
  endproperty
  a_last_drop: assert property (p_last_drop) else $error("request held in last cycle");

  property p_threshold;
    @(posedge pclk) disable iff (!presetn)
    (st_q == S_IDLE && lpend && !ctrl_q.slave_mode) |=> (lrq_q && st_q == S_REQ);
  endproperty
  a_threshold: assert property (p_threshold) else $error("no request at threshold");

  c_slow_cycle: cover property (@(posedge pclk) disable iff (!presetn) st_q == S_TWI);
  c_ext_two:    cover property (@(posedge pclk) disable iff (!presetn)
                  st_q == S_TWE ##1 st_q == S_TWE);
  c_interrupt:  cover property (@(posedge pclk) disable iff (!presetn)
                  st_q == S_T4 && rem_q && ctrl_q.tracking && lpend);
  c_slave_pop:  cover property (@(posedge pclk) disable iff (!presetn) xpop);

endmodule : dkc_dma_bus
`default_nettype wire

// ===== rtl/dkc_pkg.sv
// Shared constants, types and register map of the disk controller DMA bus engine.
// Function
// - A memory cycle without waits lasts four bus clocks, one per state.
// - The FIFO between disk side and bus side holds 32 bytes.
// - A channel's slow-strobe bit inserts one wait between second and third state.
// - Each inserted wait keeps the active read or write strobe asserted one clock longer.
// - Wait request is sampled in the third state; high with enable inserts a wait.
// - During an external wait, high inserts another wait, low advances to fourth state.
// - In tracking mode a pending local transfer interrupts a remote burst.
// - With on-chip DMA unused, a granted local request lets an outside controller read FIFO.
// - Burst either runs a programmed length or continues until the FIFO empties.
// - Addresses are a full 32 bits, covering 4 GBytes.
// - After requesting, local grant is sampled each edge; the burst starts on high.
// - Strobe is asserted from the start of second state to end of third.
// - Grant is sampled at fourth state; low grant releases the bus after the cycle.
// - In a burst's last cycle the request drops at second state start.
package dkc_pkg;

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CFG    = 8'h04;
  localparam logic [7:0] ADDR_LADDR  = 8'h08;
  localparam logic [7:0] ADDR_RADDR  = 8'h0c;
  localparam logic [7:0] ADDR_RCOUNT = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  localparam int FIFO_WORDS = 8;
  localparam int FIFO_WIDTH = 32;
  localparam int LVL_W      = 4;

  localparam int CFG_THR_LSB   = 0;
  localparam int CFG_BURST_LSB = 8;

  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [3:0]  THR_RESET    = 4'h4;
  localparam logic [3:0]  BURST_RESET  = 4'h4;
  localparam logic [31:0] ADDR_STEP    = 32'h0000_0004;

  typedef struct packed {
    logic slave_mode;
    logic until_empty;
    logic tracking;
    logic external_wait_enable;
    logic remote_slow_strobe_bit;
    logic local_slow_strobe_bit;
    logic rem_en;
    logic loc_en;
  } dkc_ctrl_s;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_REQ  = 3'b001,
    S_T1   = 3'b010,
    S_T2   = 3'b011,
    S_TWI  = 3'b100,
    S_T3   = 3'b101,
    S_TWE  = 3'b110,
    S_T4   = 3'b111
  } dkc_state_e;

endpackage : dkc_pkg

// ===== rtl/dkc_fifo.sv
// Word FIFO with valid/ready on both sides and a registered storage array.
`timescale 1ns/10ps
`default_nettype none
module dkc_fifo #(
  parameter int W = 32,
  parameter int D = 8,
  parameter int L = 4
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data,
  // Fill level in words
  output logic [L-1:0]      level
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [L-1:0]  cnt_q;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_q != L'(D));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rp_q];
  assign level     = cnt_q;

  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + L'(push) - L'(pop);
    end
  end
endmodule : dkc_fifo
`default_nettype wire

// ===== dv/dkc_mem_model.sv
// Behavioural arbiter, buffer memory and wait-request source facing the DMA engine.
`timescale 1ns/10ps
`default_nettype none
module dkc_mem_model
  import dkc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Memory bus from the engine
  input  wire logic [31:0] mem_addr,
  input  wire logic        mem_ads,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  output logic [31:0]      mem_rdata,
  output logic             external_wait_request,
  // Arbitration
  input  wire logic        local_bus_request,
  output logic             local_bus_grant,
  input  wire logic        remote_bus_request,
  output logic             remote_bus_grant,
  // Bench knobs
  input  wire logic [3:0]  grant_dly,
  input  wire logic [3:0]  hold_len
);
  localparam logic [31:0] RD_MASK = 32'h5a5a_a5a5;
  logic [31:0] adr_q;
  logic [3:0]  gcnt_q;
  logic [3:0]  scnt_q;
  logic        strobe;
  assign strobe = mem_rd | mem_wr;
  // Held high through the first hold_len-1 strobe cycles; outside a strobe it wanders.
  assign external_wait_request = strobe ? (scnt_q + 4'h1 < hold_len) : adr_q[2];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adr_q           <= 32'h0000_0000;
      gcnt_q          <= 4'h0;
      scnt_q          <= 4'h0;
      mem_rdata       <= 32'h0000_0000;
      local_bus_grant  <= 1'b0;
      remote_bus_grant <= 1'b0;
    end else begin
      if (mem_ads) begin
        adr_q <= mem_addr;
      end
      scnt_q <= strobe ? scnt_q + 4'h1 : 4'h0;
      // A released data bus shows the inverse of its last value, never a stale match.
      mem_rdata <= mem_rd ? (adr_q ^ RD_MASK) : ~mem_rdata;
      gcnt_q <= (local_bus_request | remote_bus_request) ? gcnt_q + 4'h1 : 4'h0;
      local_bus_grant  <= local_bus_request & (local_bus_grant | gcnt_q >= grant_dly);
      remote_bus_grant <= remote_bus_request & (remote_bus_grant | gcnt_q >= grant_dly);
    end
  end
endmodule : dkc_mem_model
`default_nettype wire

// ===== dv/dkc_dma_bus_test.sv
// Self-checking bench for the bus-side DMA engine.
`timescale 1ns/10ps
`default_nettype none
module dkc_dma_bus_test
  import dkc_pkg::*;
;
  localparam logic [31:0] RD_MASK = 32'h5a5a_a5a5;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, disk_data, mem_addr, mem_wdata, mem_rdata, rem_data, xdma_rdata;
  logic        disk_valid, disk_ready, mem_ads, mem_rd, mem_wr, external_wait_request;
  logic        local_bus_request, local_bus_grant, remote_bus_request, remote_bus_grant;
  logic        rem_valid, xdma_rd, sx;
  logic [3:0]  grant_dly, hold_len;
  logic [31:0] qd[$], qa[$], qb[$], qr[$], qx[$], r, b, d, la;
  logic        e;
  int          err_total, checked, exp_len, slen, wk;

  dkc_dma_bus uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .disk_valid(disk_valid), .disk_ready(disk_ready),
    .disk_data(disk_data), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ads(mem_ads), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .external_wait_request(external_wait_request), .local_bus_request(local_bus_request),
    .local_bus_grant(local_bus_grant), .remote_bus_request(remote_bus_request),
    .remote_bus_grant(remote_bus_grant), .rem_data(rem_data), .rem_valid(rem_valid),
    .xdma_rd(xdma_rd), .xdma_rdata(xdma_rdata));
  dkc_mem_model mdl (.pclk(pclk), .presetn(presetn), .mem_addr(mem_addr),
    .mem_ads(mem_ads), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_rdata(mem_rdata),
    .external_wait_request(external_wait_request), .local_bus_request(local_bus_request),
    .local_bus_grant(local_bus_grant), .remote_bus_request(remote_bus_request),
    .remote_bus_grant(remote_bus_grant), .grant_dly(grant_dly), .hold_len(hold_len));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task end_of_test;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task done_test(input string name);
    $display("test %s done, checked=%0d err_total=%0d", name, checked, err_total);
  endtask : done_test

  // An idle cycle precedes each setup so psel is never driven twice in one step.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) chk(32'h0, 32'h1, "no pready");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task push(input logic [31:0] wd);
    int k;
    disk_valid <= 1'b1;
    disk_data <= wd;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (disk_ready !== 1'b1 && k < 500);
    if (disk_ready !== 1'b1) chk(32'h0, 32'h1, "disk stream stuck");
  endtask : push

  task settle;
    int k;
    k = 0;
    // Quiet is judged between edges, so the monitor has already closed the last strobe.
    do begin
      @(negedge pclk);
      k++;
    end while ((qd.size() || qa.size() || qb.size() || qr.size() || qx.size() || slen != 0 ||
                local_bus_request !== 1'b0 || remote_bus_request !== 1'b0) && k < 3000);
    @(posedge pclk);
    if (k >= 3000) chk(32'h0, 32'h1, "engine stalled");
  endtask : settle

  always @(posedge pclk) begin
    if (presetn) begin
      if (mem_ads && remote_bus_request) begin
        chk(mem_addr, qb.size() ? qb.pop_front() : 32'hx, "remote address");
      end else if (mem_ads) begin
        chk(mem_addr, qa.size() ? qa.pop_front() : 32'hx, "address");
      end
      if (mem_wr && slen == 0) chk(mem_wdata, qd.size() ? qd.pop_front() : 32'hx, "wdata");
      if (mem_wr | mem_rd) begin
        slen++;
      end else if (slen != 0) begin
        chk(32'(slen), 32'(exp_len), "strobe length");
        slen = 0;
      end
      if (rem_valid) chk(rem_data, qr.size() ? qr.pop_front() : 32'hx, "remote data");
      if (sx) chk(xdma_rdata, qx.size() ? qx.pop_front() : 32'hx, "slave word");
      sx = xdma_rd & local_bus_request & local_bus_grant;
    end
  end

  initial begin
    #200000;
    err_total++;
    $display("ERROR %0t watchdog expired", $time);
    end_of_test;
  end

  initial begin
    {psel, penable, pwrite, disk_valid, xdma_rd, presetn} = '0;
    {paddr, pwdata, disk_data, grant_dly, hold_len} = '0;
    slen = 0;
    r = $urandom(3735);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'(local_bus_request), 32'h0, "request after reset");
    chk(32'(disk_ready), 32'h1, "disk ready after reset");
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(r, 32'(CTRL_RESET), "ctrl reset");
    apb(1'b0, ADDR_CFG, 32'h0);
    chk(r, {20'h0, BURST_RESET, 4'h0, THR_RESET}, "cfg reset");
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(e), 32'h1, "unmapped refused");
    done_test("reset");
    // Every mix of slow strobe, external wait enable and a slow memory.
    for (int c = 0; c < 8; c++) begin
      grant_dly <= 4'($urandom % 4);
      hold_len <= c[2] ? 4'h5 : 4'h0;
      exp_len = (c[1] && c[2]) ? 5 : 2 + c[0];
      b = $urandom & 32'hffff_fffc;
      apb(1'b1, ADDR_LADDR, b);
      apb(1'b1, ADDR_CTRL, {27'h0, c[1], 1'b0, c[0], 2'b01});
      for (int i = 0; i < 4; i++) begin
        d = $urandom;
        qd.push_back(d);
        qa.push_back(b + 32'(4 * i));
        push(d);
      end
      disk_valid <= 1'b0;
      settle;
      apb(1'b1, ADDR_CTRL, 32'h0);
    end
    done_test("local");
    // Fill the FIFO until it refuses, then drain it in one burst.
    b = $urandom & 32'hffff_fffc;
    hold_len <= 4'h0;
    exp_len = 2;
    apb(1'b1, ADDR_LADDR, b);
    for (int i = 0; i < FIFO_WORDS; i++) begin
      d = $urandom;
      qd.push_back(d);
      qa.push_back(b + 32'(4 * i));
      push(d);
    end
    @(posedge pclk);
    chk(32'(disk_ready), 32'h0, "full refuses");
    disk_valid <= 1'b0;
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r, 32'h0000_0008, "level full");
    apb(1'b1, ADDR_CTRL, 32'h0000_0041);
    settle;
    apb(1'b1, ADDR_CTRL, 32'h0);
    done_test("fill");
    // Remote reads with slow strobe and external waits together.
    b = $urandom & 32'hffff_fffc;
    hold_len <= 4'h4;
    exp_len = 4;
    for (int i = 0; i < 3; i++) begin
      qb.push_back(b + 32'(4 * i));
      qr.push_back((b + 32'(4 * i)) ^ RD_MASK);
    end
    apb(1'b1, ADDR_RADDR, b);
    apb(1'b1, ADDR_RCOUNT, 32'h0000_0003);
    apb(1'b1, ADDR_CTRL, 32'h0000_001a);
    settle;
    apb(1'b1, ADDR_CTRL, 32'h0);
    done_test("remote");
    // A long remote stream with a burst of 16 must give way to a local burst.
    b = $urandom & 32'hffff_fffc;
    la = $urandom & 32'hffff_fffc;
    exp_len = 2;
    for (int i = 0; i < 8; i++) begin
      qb.push_back(b + 32'(4 * i));
      qr.push_back((b + 32'(4 * i)) ^ RD_MASK);
      if (i < 4) qa.push_back(la + 32'(4 * i));
    end
    apb(1'b1, ADDR_CFG, {20'h0, 4'h0, 4'h0, THR_RESET});
    apb(1'b1, ADDR_LADDR, la);
    apb(1'b1, ADDR_RADDR, b);
    apb(1'b1, ADDR_RCOUNT, 32'h0000_0008);
    apb(1'b1, ADDR_CTRL, 32'h0000_0023);
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      qd.push_back(d);
      push(d);
    end
    disk_valid <= 1'b0;
    wk = 0;
    while (qd.size() && wk < 500) begin
      @(posedge pclk);
      wk++;
    end
    apb(1'b0, ADDR_RCOUNT, 32'h0);
    chk(32'(r != 32'h0), 32'h1, "remote not cut short");
    settle;
    apb(1'b1, ADDR_CTRL, 32'h0);
    done_test("tracking");
    // An outside controller empties the FIFO while the engine is a slave.
    apb(1'b1, ADDR_CTRL, 32'h0000_0081);
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      qx.push_back(d);
      push(d);
    end
    disk_valid <= 1'b0;
    xdma_rd <= 1'b1;
    settle;
    xdma_rd <= 1'b0;
    done_test("slave");
    end_of_test;
  end
endmodule : dkc_dma_bus_test
`default_nettype wire
